// ### design/addr_term.sv
// Processor-bus address tenure termination: byte lanes, misaligned
// splitting, addr_ack timing, retry window, re-snoop and grant.
// Assumes all bus pins are on clk_sys; pins are split in/out/enable.
`timescale 1ns/1ns
`include "addr_term_regs.svh"

// Functional notes
// - Unused lanes ignored on read, zero on write
// - Lane 0 data_high 0-7, lane 7 data_low 24-31
// - Misaligned inside one word: single transfer
// - Word-crossing access becomes two transfers, except size 0 (eight bytes): one transfer
// - Tenure ends at addr_ack; next clock retry window
// - Drive addr_ack unless cache controller claims tenure
// - addr_ack stays released until needed
// - Own tenures: only others give snoop response
// - Re-snoop retried tenure per repeat_snoop_sel, snoop push
// - Retry on castout, buffer collision, busy host bus
// - Retry from after start to clock after addr_ack
// - Grant address bus to requesting snoop-hit processor
// - One-level pipeline: ack waits for data tenure end
// - Processor ack withheld while retry still possible
// - Processor ack after cache_claim_delay and addr_phase_wait
// - addr_phase_wait is a minimum wait count
// - snoop_wait is minimum wait before valid snoop
// - Own tenures wait snoop_wait plus pipeline state
module addr_term (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic transfer_start_n,
	input wire logic [31:0] bus_addr,
	input wire logic [2:0] transfer_size,
	input wire logic global_n,
	input wire logic l2_claim,
	input wire logic bus_request_n,
	input wire logic addr_ack_in,
	output logic addr_ack_out,
	output logic addr_ack_oe,
	input wire logic addr_retry_in,
	output logic addr_retry_out,
	output logic addr_retry_oe,
	output logic start_out_n,
	output logic start_oe,
	output logic [31:0] addr_out,
	output logic [2:0] size_out,
	input wire logic castout,
	input wire logic buf_collision,
	input wire logic host_busy,
	input wire logic retry_possible,
	input wire logic data_busy,
	input wire addr_term_pkg::xfer_req_t dreq,
	output logic dreq_ready,
	output logic dreq_done,
	output logic dreq_retried,
	output logic proc_grant,
	output logic [0:7] lane_mask,
	input wire logic [0:63] wdata,
	output logic [0:31] data_high_out,
	output logic [0:31] data_low_out,
	input wire logic [0:31] data_high_in,
	input wire logic [0:31] data_low_in,
	output logic [0:63] rdata_out
);

	addr_term_pkg::state_rec_t r;
	addr_term_pkg::state_rec_t next_r;
	logic [0:7] lane_sel;
	logic [0:63] w_bytes;
	logic [0:63] r_bytes;
	logic [3:0] len;
	logic [3:0] off;
	logic [3:0] first_len;
	logic [3:0] proc_tgt;
	logic cause;

	// Lane i covers bytes off..off+len-1 of the double word
	function automatic logic [0:7] lanes_of(input logic [2:0] a, input logic [2:0] sz);
		logic [3:0] n;
		logic [3:0] o;
		logic [0:7] m;
		n = (sz == 3'h0) ? 4'h8 : {1'b0, sz};
		o = {1'b0, a};
		m = 8'h00;
		for (int i = 0; i < `ATR_LANES; i++) begin
			m[i] = (4'(i) >= o) && (4'(i) < o + n);
		end
		return m;
	endfunction : lanes_of

	assign lane_sel = r.lanes;

	generate
		for (genvar g = 0; g < `ATR_LANES; g++) begin : g_lane
			// Lanes outside the operand carry zeros rather than stale data
			assign w_bytes[8*g +: 8] = lane_sel[g] ? wdata[8*g +: 8] : 8'h00;
			if (g < 4) begin : g_hi
				assign r_bytes[8*g +: 8] = lane_sel[g] ? data_high_in[8*g +: 8] : 8'h00;
			end else begin : g_lo
				assign r_bytes[8*g +: 8] = lane_sel[g] ? data_low_in[8*(g-4) +: 8] : 8'h00;
			end
		end
	endgenerate

	always_comb begin
		off = {2'b00, dreq.addr[1:0]};
		len = (dreq.size == 3'h0) ? 4'h8 : {1'b0, dreq.size};
		first_len = `ATR_WORD_BYTES - off;
		proc_tgt = (r.aph > r.l2d) ? r.aph : r.l2d;
		cause = (castout | buf_collision | host_busy) & ~r.own & r.glob;
		next_r = r;
		next_r.grant = 1'b0;
		next_r.done = 1'b0;
		next_r.start_n = 1'b1;
		next_r.start_oe = 1'b0;
		next_r.rdata = 32'h0000_0000;
		next_r.dout = w_bytes;
		next_r.din = r_bytes;

		if (reg_wr) begin
			if (reg_addr == `ATR_OFS_CFG1) begin
				next_r.loop = reg_wdata[`ATR_CFG1_LOOP];
			end else if (reg_addr == `ATR_OFS_CFG2) begin
				next_r.aph = reg_wdata[`ATR_CFG2_APH +: `ATR_WS_W];
				next_r.l2d = reg_wdata[`ATR_CFG2_L2D +: `ATR_WS_W];
				next_r.snw = reg_wdata[`ATR_CFG2_SNW +: `ATR_WS_W];
			end
		end
		if (reg_rd) begin
			if (reg_addr == `ATR_OFS_CFG1) begin
				next_r.rdata[`ATR_CFG1_LOOP] = r.loop;
			end else if (reg_addr == `ATR_OFS_CFG2) begin
				next_r.rdata[`ATR_CFG2_APH +: `ATR_WS_W] = r.aph;
				next_r.rdata[`ATR_CFG2_L2D +: `ATR_WS_W] = r.l2d;
				next_r.rdata[`ATR_CFG2_SNW +: `ATR_WS_W] = r.snw;
			end else if (reg_addr == `ATR_OFS_STAT) begin
				next_r.rdata = {20'h00000, r.cnt, r.sec, r.rtyd, r.own, r.st, r.glob, r.dretried};
			end
		end

		// Device drives retry only while the tenure can still be retried
		if ((r.st == addr_term_pkg::ST_WAIT) || (r.st == addr_term_pkg::ST_ACK)) begin
			next_r.rty_n = ~cause;
			next_r.rty_oe = cause;
		end else begin
			next_r.rty_n = 1'b1;
			next_r.rty_oe = 1'b0;
		end

		case (r.st)
			addr_term_pkg::ST_IDLE: begin
				next_r.ack_oe = 1'b0;
				next_r.ack_n = 1'b1;
				next_r.rtyd = 1'b0;
				next_r.cnt = 4'h0;
				if (!transfer_start_n) begin
					next_r.own = 1'b0;
					next_r.glob = ~global_n;
					next_r.a_addr = bus_addr;
					next_r.a_size = transfer_size;
					next_r.lanes = lanes_of(bus_addr[2:0], transfer_size);
					next_r.ready = 1'b0;
					next_r.st = addr_term_pkg::ST_WAIT;
				end else if (r.sec || (dreq.valid && r.ready)) begin
					next_r.own = 1'b1;
					next_r.glob = 1'b1;
					next_r.ready = 1'b0;
					if (!r.sec) begin
						next_r.a_addr = dreq.addr;
						next_r.a_size = dreq.size;
						if (dreq.size != 3'h0 && off + len > `ATR_WORD_BYTES) begin
							next_r.a_size = first_len[2:0];
							next_r.sec = 1'b1;
							next_r.s_addr = {dreq.addr[31:2] + 30'h1, 2'b00};
							next_r.s_size = 3'(len - first_len);
						end else begin
							next_r.sec = 1'b0;
						end
					end
					next_r.st = addr_term_pkg::ST_DTS;
				end
			end
			addr_term_pkg::ST_DTS: begin
				next_r.start_n = 1'b0;
				next_r.start_oe = 1'b1;
				next_r.lanes = lanes_of(r.a_addr[2:0], r.a_size);
				next_r.st = addr_term_pkg::ST_WAIT;
			end
			addr_term_pkg::ST_WAIT: begin
				next_r.cnt = (r.cnt == 4'hf) ? r.cnt : r.cnt + 4'h1;
				if (!r.own && (r.cnt == r.l2d) && l2_claim) begin
					next_r.st = addr_term_pkg::ST_EXT;
				end else if (r.own) begin
					if ((r.cnt >= r.snw) && !data_busy) begin
						next_r.ack_n = 1'b0;
						next_r.ack_oe = 1'b1;
						next_r.st = addr_term_pkg::ST_ACK;
					end
				end else if ((r.cnt >= proc_tgt) && !data_busy && !retry_possible) begin
					next_r.ack_n = 1'b0;
					next_r.ack_oe = 1'b1;
					next_r.st = addr_term_pkg::ST_ACK;
				end
			end
			addr_term_pkg::ST_EXT: begin
				// Controller owns addr_ack and negates it itself
				if (!addr_ack_in) begin
					next_r.st = addr_term_pkg::ST_WIN;
				end
			end
			addr_term_pkg::ST_ACK: begin
				// One negated clock before release precharges the line
				next_r.ack_n = 1'b1;
				next_r.st = addr_term_pkg::ST_WIN;
			end
			addr_term_pkg::ST_WIN: begin
				next_r.ack_oe = 1'b0;
				next_r.rtyd = ~addr_retry_in;
				next_r.st = addr_term_pkg::ST_GAP;
			end
			addr_term_pkg::ST_GAP: begin
				next_r.st = addr_term_pkg::ST_IDLE;
				if (r.rtyd && !bus_request_n && !r.own) begin
					next_r.grant = 1'b1;
				end
				if (r.own) begin
					if (r.rtyd && (r.loop || bus_request_n)) begin
						next_r.st = addr_term_pkg::ST_DTS;
						next_r.cnt = 4'h0;
					end else if (r.rtyd) begin
						next_r.done = 1'b1;
						next_r.dretried = 1'b1;
						next_r.sec = 1'b0;
						next_r.ready = 1'b1;
					end else if (r.sec) begin
						next_r.a_addr = r.s_addr;
						next_r.a_size = r.s_size;
						next_r.sec = 1'b0;
						next_r.st = addr_term_pkg::ST_DTS;
						next_r.cnt = 4'h0;
					end else begin
						next_r.done = 1'b1;
						next_r.dretried = 1'b0;
						next_r.ready = 1'b1;
					end
				end else begin
					next_r.ready = ~r.sec;
				end
			end
			default: begin
				next_r.st = addr_term_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			r <= '0;
			r.st <= addr_term_pkg::ST_IDLE;
			r.ack_n <= 1'b1;
			r.rty_n <= 1'b1;
			r.start_n <= 1'b1;
			r.ready <= 1'b1;
			r.loop <= `ATR_LOOP_RST;
			r.aph <= `ATR_APH_RST;
			r.l2d <= `ATR_L2D_RST;
			r.snw <= `ATR_SNW_RST;
		end else begin
			r <= next_r;
		end
	end

	assign reg_rdata = r.rdata;
	assign addr_ack_out = r.ack_n;
	assign addr_ack_oe = r.ack_oe;
	assign addr_retry_out = r.rty_n;
	assign addr_retry_oe = r.rty_oe;
	assign start_out_n = r.start_n;
	assign start_oe = r.start_oe;
	assign addr_out = r.a_addr;
	assign size_out = r.a_size;
	assign dreq_ready = r.ready;
	assign dreq_done = r.done;
	assign dreq_retried = r.dretried;
	assign proc_grant = r.grant;
	assign lane_mask = r.lanes;
	assign data_high_out = r.dout[0:31];
	assign data_low_out = r.dout[32:63];
	assign rdata_out = r.din;

endmodule : addr_term

// ### design/addr_term_regs.svh
// Register offsets, field positions, reset values and widths for the
// processor-bus address termination block.
// Assumes one bus clock and a byte-addressed plain register port.
`ifndef ADDR_TERM_REGS_SVH
`define ADDR_TERM_REGS_SVH

`define ATR_OFS_CFG1 8'h00
`define ATR_OFS_CFG2 8'h04
`define ATR_OFS_STAT 8'h08

`define ATR_CFG1_LOOP 0

`define ATR_WS_W 4
`define ATR_CFG2_APH 0
`define ATR_CFG2_L2D 4
`define ATR_CFG2_SNW 8

`define ATR_APH_RST 4'h1
`define ATR_L2D_RST 4'h1
`define ATR_SNW_RST 4'h1
`define ATR_LOOP_RST 1'b0

`define ATR_WORD_BYTES 4'h4
`define ATR_LANES 8

`endif

// ### design/addr_term_pkg.sv
// Types shared by the address termination block: state encoding,
// request carrier and the packed state record.
// Assumes addr_term_regs.svh is included before use.
`include "addr_term_regs.svh"

package addr_term_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_DTS = 3'h1,
		ST_WAIT = 3'h3,
		ST_ACK = 3'h2,
		ST_WIN = 3'h6,
		ST_GAP = 3'h7,
		ST_EXT = 3'h5
	} state_t;

	typedef struct packed {
		logic valid;
		logic [31:0] addr;
		logic [2:0] size;
	} xfer_req_t;

	typedef struct packed {
		state_t st;
		logic [3:0] cnt;
		logic own;
		logic glob;
		logic rtyd;
		logic ack_n;
		logic ack_oe;
		logic rty_n;
		logic rty_oe;
		logic start_n;
		logic start_oe;
		logic [31:0] a_addr;
		logic [2:0] a_size;
		logic sec;
		logic [31:0] s_addr;
		logic [2:0] s_size;
		logic loop;
		logic [3:0] aph;
		logic [3:0] l2d;
		logic [3:0] snw;
		logic [31:0] rdata;
		logic grant;
		logic done;
		logic dretried;
		logic ready;
		logic [0:7] lanes;
		logic [0:63] dout;
		logic [0:63] din;
	} state_rec_t;

endpackage : addr_term_pkg

// ### tb/addr_term_chk.sv
// Checker: address tenure relations seen at the termination block's ports.
// Assumes one bus clock; the ack line level is fed back on addr_ack_in.
`timescale 1ns/1ns
module addr_term_chk (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic transfer_start_n,
	input wire logic global_n,
	input wire logic bus_request_n,
	input wire logic data_busy,
	input wire logic addr_ack_in,
	input wire logic addr_ack_out,
	input wire logic addr_ack_oe,
	input wire logic addr_retry_oe,
	input wire logic start_out_n,
	input wire logic start_oe,
	input wire logic [31:0] addr_out,
	input wire logic [2:0] size_out,
	input wire logic proc_grant
);
	logic proc, ackd, glob_n;
	// Processor tenure is open from its start until the retry window has passed
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			proc <= 1'b0;
			ackd <= 1'b0;
			glob_n <= 1'b1;
		end else begin
			ackd <= !addr_ack_in;
			if (ackd)
				proc <= 1'b0;
			else if (!transfer_start_n && !proc) begin
				proc <= 1'b1;
				glob_n <= global_n;
			end
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	sequence ack_low_s;
		addr_ack_oe && !addr_ack_out;
	endsequence
	sequence ack_tail_s;
		addr_ack_oe && addr_ack_out ##1 !addr_ack_oe;
	endsequence
	ack_pulse_a: assert property (ack_low_s |=> ack_tail_s) else $error("ack pulse bad");
	ack_drive_a: assert property ($rose(addr_ack_oe) |-> !addr_ack_out) else $error("ack oe early");
	ack_busy_a: assert property (data_busy |=> !(addr_ack_oe && !addr_ack_out)) else $error("ack busy");
	retry_span_a: assert property (addr_retry_oe |-> proc || $past(proc)) else $error("retry span");
	retry_global_a: assert property (addr_retry_oe |-> !glob_n) else $error("retry local");
	grant_req_a: assert property (proc_grant |-> !$past(bus_request_n) ##1 !proc_grant)
		else $error("grant bad");
	split_size_a: assert property (start_oe && !start_out_n && size_out != 3'h0
		|-> {2'h0, addr_out[1:0]} + {1'h0, size_out} <= 4'h4) else $error("word crossed");
	own_wait_a: assert property (start_oe && !start_out_n
		|=> !(addr_ack_oe && !addr_ack_out)) else $error("own ack early");
endmodule : addr_term_chk

bind addr_term addr_term_chk i_chk (.clk_sys, .arst_n, .transfer_start_n, .global_n,
	.bus_request_n, .data_busy, .addr_ack_in, .addr_ack_out, .addr_ack_oe, .addr_retry_oe,
	.start_out_n, .start_oe, .addr_out, .size_out, .proc_grant);

// ### tb/proc_bus_model.sv
// Far side: a snooping processor and an external cache controller on ack/retry.
// Assumes both lines are pulled up and all agents change them after clk_sys rises.
`timescale 1ns/1ns
module proc_bus_model (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic claim_go,
	input wire logic retry_go,
	input wire logic global_n,
	input wire logic addr_ack_out,
	input wire logic addr_ack_oe,
	input wire logic addr_retry_out,
	input wire logic addr_retry_oe,
	output logic ack_line,
	output logic retry_line
);
	logic [2:0] step;
	logic l2_oe, l2_ack_n, snoop_n;
	// Released lines float to the pull-up level
	assign ack_line = (l2_oe ? l2_ack_n : 1'b1) & (addr_ack_oe ? addr_ack_out : 1'b1);
	assign retry_line = snoop_n & (addr_retry_oe ? addr_retry_out : 1'b1);
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			step <= 3'h0;
			l2_oe <= 1'b0;
			l2_ack_n <= 1'b1;
			snoop_n <= 1'b1;
		end else begin
			// Late enough that the block has sampled the claim first
			step <= !claim_go ? 3'h0 : step + {2'h0, step != 3'h7};
			l2_oe <= step == 3'h4 || step == 3'h5;
			l2_ack_n <= step != 3'h4;
			snoop_n <= !(!ack_line && retry_go && !global_n);
		end
	end
endmodule : proc_bus_model

// ### tb/addr_term_tb_top.sv
// Testbench: processor and own tenures, config registers and byte lanes of addr_term.
// Assumes proc_bus_model resolves the ack and retry lines.
`timescale 1ns/1ns
`include "addr_term_regs.svh"
module addr_term_tb_top;
	logic clk_sys = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, transfer_start_n = 1'b1;
	logic global_n = 1'b0, l2_claim = 1'b0, bus_request_n = 1'b1;
	logic data_busy = 1'b0, retry_possible = 1'b0, retry_go;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, bus_addr = 32'h0, seed = 32'ha7040a2b;
	logic [2:0] transfer_size = 3'h0, cz = 3'h0;
	logic [0:63] wdata = 64'h0, din = 64'h0;
	addr_term_pkg::xfer_req_t dreq = '0;
	logic [31:0] reg_rdata, addr_out;
	logic [2:0] size_out;
	logic addr_ack_out, addr_ack_oe, addr_retry_out, addr_retry_oe, start_out_n, start_oe;
	logic dreq_ready, dreq_done, dreq_retried, proc_grant, ack_line, retry_line;
	logic [0:7] lane_mask;
	logic [0:31] data_high_out, data_low_out;
	logic [0:63] rdata_out;
	logic [34:0] tsq[$];
	int errors = 0, comparisons = 0, rty_left = 0;
	// Rows: claim, bus request, snoop retry, global_n, castout, collision, busy, hold x2
	localparam logic [8:0] TBL [9] = '{9'h000, 9'h001, 9'h002, 9'h010, 9'h028, 9'h004,
		9'h0c0, 9'h040, 9'h100};
	assign retry_go = rty_left > 0;
	addr_term i_dut (.clk_sys, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.transfer_start_n, .bus_addr, .transfer_size, .global_n, .l2_claim, .bus_request_n,
		.addr_ack_in(ack_line), .addr_ack_out, .addr_ack_oe, .addr_retry_in(retry_line),
		.addr_retry_out, .addr_retry_oe, .start_out_n, .start_oe, .addr_out, .size_out,
		.castout(cz[2]), .buf_collision(cz[1]), .host_busy(cz[0]), .retry_possible,
		.data_busy, .dreq, .dreq_ready, .dreq_done, .dreq_retried, .proc_grant, .lane_mask,
		.wdata, .data_high_out, .data_low_out, .data_high_in(din[0:31]),
		.data_low_in(din[32:63]), .rdata_out);
	proc_bus_model i_model (.clk_sys, .arst_n, .claim_go(l2_claim), .retry_go, .global_n,
		.addr_ack_out, .addr_ack_oe, .addr_retry_out, .addr_retry_oe, .ack_line, .retry_line);
	initial begin
		forever #50 clk_sys = ~clk_sys;
	end
	always @(negedge clk_sys) begin
		if (start_oe && !start_out_n)
			tsq.push_back({addr_out, size_out});
		if (retry_line === 1'b0 && rty_left > 0)
			rty_left--;
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		comparisons++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			errors++;
		end
	endtask : chk
	task automatic report_and_stop();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic reg_acc(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_sys);
		{reg_wr, reg_rd, reg_addr, reg_wdata} <= {wr, !wr, a, d};
		@(posedge clk_sys);
		{reg_wr, reg_rd} <= 2'b00;
		@(negedge clk_sys);
		q = reg_rdata;
	endtask : reg_acc
	task automatic pt(input logic [8:0] r);
		logic [3:0] ap, ld, mx, ln;
		logic [2:0] a3;
		logic [0:7] em;
		logic [0:63] m;
		logic [31:0] q;
		logic rt;
		int n;
		ap = 4'(1 + rnd() % 6);
		// Cache claim point never outlasts the processor wait count
		ld = r[8] ? 4'h1 : 4'(1 + rnd() % ap);
		mx = (ap > ld) ? ap : ld;
		reg_acc(1'b1, `ATR_OFS_CFG2, {20'h0, 4'h1, ld, ap}, q);
		a3 = 3'(rnd());
		// A processor never crosses a word; only an aligned double word is size 8
		ln = (a3 == 3'h0 && rnd() % 2 == 1) ? 4'h8 : 4'(1 + rnd() % (4 - a3[1:0]));
		for (int i = 0; i < 8; i++) begin
			em[i] = i >= a3 && i < a3 + ln;
			m[i*8 +: 8] = {8{em[i]}};
		end
		rty_left = r[6];
		q = rnd();
		@(posedge clk_sys);
		{transfer_start_n, bus_addr, transfer_size, global_n} <= {1'b0, q[31:3], a3, ln[2:0], r[5]};
		{l2_claim, cz, retry_possible, data_busy} <= {r[8], r[4:0]};
		{wdata, din} <= {rnd(), rnd(), rnd(), rnd()};
		n = 0;
		do begin
			@(posedge clk_sys);
			transfer_start_n <= 1'b1;
			// Holds drop in cycle 10, after every wait count has run out
			if (n == 9)
				{data_busy, retry_possible} <= 2'b00;
			@(negedge clk_sys);
			n++;
		end while (ack_line !== 1'b0 && n < 60);
		chk("ack seen", 0, ack_line);
		if (!r[8])
			chk("ack latency", (r[1:0] != 2'h0) ? 11 : mx + 2, n);
		chk("device ack drive", !r[8], addr_ack_oe);
		chk("lane mask", em, lane_mask);
		chk("write lanes", wdata & m, {data_high_out, data_low_out});
		chk("read lanes", din & m, rdata_out);
		rt = !r[5] && (r[6] || r[4:2] != 3'h0);
		@(negedge clk_sys);
		chk("retry window", !rt, retry_line);
		@(posedge clk_sys);
		{bus_request_n, cz} <= {!r[7], 3'h0};
		@(negedge clk_sys);
		@(negedge clk_sys);
		chk("grant", rt && r[7], proc_grant);
		@(posedge clk_sys);
		{bus_request_n, l2_claim} <= 2'b10;
	endtask : pt
	task automatic ot(input logic [31:0] a, input logic [2:0] s, input logic lp, input logic br,
		input int rr, input logic exr);
		logic [31:0] q;
		logic [3:0] ln;
		logic [2:0] f;
		int n;
		reg_acc(1'b1, `ATR_OFS_CFG1, {31'h0, lp}, q);
		chk("ready idle", 1, dreq_ready);
		tsq.delete();
		rty_left = rr;
		@(posedge clk_sys);
		{dreq, bus_request_n, global_n} <= {1'b1, a, s, !br, 1'b0};
		@(posedge clk_sys);
		dreq.valid <= 1'b0;
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (dreq_done !== 1'b1 && n < 300);
		chk("done seen", 1, dreq_done);
		chk("retried flag", exr, dreq_retried);
		ln = (s == 3'h0) ? 4'h8 : {1'b0, s};
		f = 3'h4 - {1'b0, a[1:0]};
		if (s != 3'h0 && a[1:0] + ln > 4) begin
			chk("start count", 2, tsq.size());
			chk("first part", {a, f}, tsq[0]);
			chk("second part", {(a & ~32'h3) + 32'h4, 3'(ln - f)}, tsq[1]);
		end else
			chk("start count", exr ? rr : rr + 1, tsq.size());
		@(posedge clk_sys);
		bus_request_n <= 1'b1;
	endtask : ot
	initial begin
		logic [31:0] q;
		repeat (12) @(posedge clk_sys);
		arst_n <= 1'b1;
		reg_acc(1'b0, `ATR_OFS_CFG1, 32'h0, q);
		chk("cfg1 reset", 32'h0, q);
		reg_acc(1'b0, `ATR_OFS_CFG2, 32'h0, q);
		chk("cfg2 reset", {20'h0, `ATR_SNW_RST, `ATR_L2D_RST, `ATR_APH_RST}, q);
		reg_acc(1'b0, 8'h0c, 32'h0, q);
		chk("unmapped read", 32'h0, q);
		$display("test registers done");
		foreach (TBL[i])
			pt(TBL[i]);
		repeat (6) pt(9'(rnd() & 32'h3c));
		$display("test processor tenures done");
		for (int j = 0; j < 8; j++) begin
			q = rnd();
			// Operand stays inside its double word, so a split never needs a third part
			ot({q[31:3], 3'(j)}, (j == 0) ? 3'h0 : 3'(1 + rnd() % (8 - j)), 1'b0, 1'b0, 0, 1'b0);
		end
		ot(32'h100, 3'h4, 1'b0, 1'b1, 1, 1'b1);
		ot(32'h200, 3'h4, 1'b1, 1'b1, 2, 1'b0);
		ot(32'h300, 3'h4, 1'b0, 1'b0, 2, 1'b0);
		$display("test own tenures done");
		report_and_stop();
	end
	initial begin
		repeat (8000) @(posedge clk_sys);
		errors++;
		report_and_stop();
	end
endmodule : addr_term_tb_top
